/* verilog/mpcs_power_sequencer.sv */
`timescale 1ns/100ps
`include "mpcs_regs.svh"
// Notes on behaviour
// RULE_01 - host drives control pins open-drain only
// RULE_02 - host holds supply-enable low 10 ms
// RULE_03 - regulator ready 2 ms after enable release
// RULE_04 - supply-enable only for power cycling
// RULE_05 - host holds reset low 200 ms
// RULE_06 - reset only for unresponsive modem recovery
// RULE_07 - toggle acts only after pin released
// RULE_08 - on needs 5 s low hold
// RULE_09 - off needs 3 s low hold
// RULE_10 - host waits for monitor before retoggle
// RULE_11 - power-down detaches from network first
// RULE_12 - host keeps inputs low during power-on
// RULE_13 - software command may request power-down
// RULE_14 - monitor high when on, low off
// RULE_15 - inputs driven high block monitor fall
// RULE_16 - host times holds with margin
module mpcs_power_sequencer #(
  parameter int unsigned ON_HOLD_CYC = `MPCS_ON_HOLD_CYC,
  parameter int unsigned OFF_HOLD_CYC = `MPCS_OFF_HOLD_CYC,
  parameter int unsigned REG_START_CYC = `MPCS_REG_START_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // control pins, levels as seen on the pulled-up wires
  input wire logic supply_en_n_i,
  input wire logic modem_rst_n_i,
  input wire logic toggle_n_i,
  // signal inputs from host, any high blocks power-down
  input wire logic host_inputs_high_i,
  // software power-down command, one-cycle pulse
  input wire logic sw_off_req_i,
  // network detach handshake
  output logic detach_req_o,
  input wire logic detach_done_i,
  // status
  output logic power_state_monitor_o,
  output logic auxiliary_supply_out_o,
  output logic regulator_ok_o
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  mpcs_pkg::mpcs_state_t state_q, state_d;
  logic [`MPCS_CNT_W-1:0] hold_q, hold_d;
  logic [`MPCS_CNT_W-1:0] reg_q, reg_d;
  logic tog_q, tog_d;
  logic mon_q, mon_d;

  // ----------------------------------------------------------------------
  // state decoding, shared by next-state logic and outputs
  // ----------------------------------------------------------------------
  function automatic logic is_powered(input mpcs_pkg::mpcs_state_t s);
    return (s == mpcs_pkg::MPCS_ON) || (s == mpcs_pkg::MPCS_DETACH);
  endfunction : is_powered

  // the regulator is up in every state but the two supply states
  function automatic logic has_regulator(input mpcs_pkg::mpcs_state_t s);
    return (s != mpcs_pkg::MPCS_DISABLED)
           && (s != mpcs_pkg::MPCS_REG_START);
  endfunction : has_regulator

  wire logic tog_release = tog_q && toggle_n_i;

  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    reg_d = reg_q;
    tog_d = !toggle_n_i;
    // hold counter only advances while the pin is low
    if (!toggle_n_i) begin
      if (hold_q != '1) begin
        hold_d = hold_q + `MPCS_CNT_W'(1);
      end
    end else begin
      hold_d = '0;
    end
    case (state_q)
      mpcs_pkg::MPCS_DISABLED: begin
        reg_d = '0;
        if (supply_en_n_i) begin
          state_d = mpcs_pkg::MPCS_REG_START;
        end
      end
      mpcs_pkg::MPCS_REG_START: begin
        if (reg_q >= `MPCS_CNT_W'(REG_START_CYC - 1)) begin // see RULE_03
          state_d = mpcs_pkg::MPCS_OFF;
        end else begin
          reg_d = reg_q + `MPCS_CNT_W'(1);
        end
      end
      mpcs_pkg::MPCS_OFF: begin
        // switching only on release, after a long enough hold
        if (tog_release && hold_q >= `MPCS_CNT_W'(ON_HOLD_CYC)) begin // see RULE_07 see RULE_08
          state_d = mpcs_pkg::MPCS_ON;
        end
      end
      mpcs_pkg::MPCS_ON: begin
        if ((tog_release && hold_q >= `MPCS_CNT_W'(OFF_HOLD_CYC))
            || sw_off_req_i) begin // see RULE_09 see RULE_13
          state_d = mpcs_pkg::MPCS_DETACH;
        end
      end
      mpcs_pkg::MPCS_DETACH: begin
        // monitor stays high until detached and host inputs quiet
        if (detach_done_i && !host_inputs_high_i) begin // see RULE_11 see RULE_15
          state_d = mpcs_pkg::MPCS_OFF;
        end
      end
      default: begin
        state_d = mpcs_pkg::MPCS_DISABLED;
      end
    endcase
    // reset sends a running modem back off; enable low overrides all
    if (!modem_rst_n_i && has_regulator(state_q)) begin
      state_d = mpcs_pkg::MPCS_OFF;
    end
    if (!supply_en_n_i) begin
      state_d = mpcs_pkg::MPCS_DISABLED;
    end
    mon_d = is_powered(state_d); // see RULE_14
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= mpcs_pkg::MPCS_DISABLED;
      hold_q <= '0;
      reg_q <= '0;
      tog_q <= 1'h0;
      mon_q <= 1'h0;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
      reg_q <= reg_d;
      tog_q <= tog_d;
      mon_q <= mon_d;
    end
  end

  assign power_state_monitor_o = mon_q;
  assign auxiliary_supply_out_o = mon_q;
  assign detach_req_o = (state_q == mpcs_pkg::MPCS_DETACH);
  assign regulator_ok_o = has_regulator(state_q);

  // ----------------------------------------------------------------------
  // checker helpers
  // ----------------------------------------------------------------------
  // counted apart from hold_q and reg_q so a fault there cannot hide
  logic [`MPCS_CNT_W-1:0] tlow_q, tlow_d;
  logic [`MPCS_CNT_W-1:0] en_up_q, en_up_d;

  always_comb begin
    tlow_d = '0;
    en_up_d = '0;
    if (!toggle_n_i) begin
      tlow_d = (tlow_q == '1) ? tlow_q : tlow_q + `MPCS_CNT_W'(1);
    end
    if (supply_en_n_i) begin
      en_up_d = (en_up_q == '1) ? en_up_q : en_up_q + `MPCS_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tlow_q <= '0;
      en_up_q <= '0;
    end else begin
      tlow_q <= tlow_d;
      en_up_q <= en_up_d;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  a_mon_tracks_state: assert property ( // see RULE_14
    power_state_monitor_o == (state_q == mpcs_pkg::MPCS_ON
                              || state_q == mpcs_pkg::MPCS_DETACH))
    else $error("monitor does not match power state");
  a_aux_follows_mon: assert property ( // see RULE_14
    auxiliary_supply_out_o == power_state_monitor_o)
    else $error("aux supply differs from monitor");
  a_no_on_while_low: assert property ( // see RULE_07
    (!toggle_n_i && !power_state_monitor_o && supply_en_n_i)
    |=> !power_state_monitor_o)
    else $error("modem switched on while toggle held low");
  a_short_pulse_ignored: assert property ( // see RULE_08
    (state_q == mpcs_pkg::MPCS_OFF && tog_release
     && hold_q < `MPCS_CNT_W'(ON_HOLD_CYC) && supply_en_n_i)
    |=> !power_state_monitor_o)
    else $error("short pulse switched modem on");
  a_off_via_detach: assert property ( // see RULE_11
    $fell(power_state_monitor_o) && $past(supply_en_n_i)
    && $past(modem_rst_n_i) |-> $past(state_q) == mpcs_pkg::MPCS_DETACH)
    else $error("power-down skipped network detach");
  a_sw_off_detach: assert property ( // see RULE_13
    (state_q == mpcs_pkg::MPCS_ON && sw_off_req_i && supply_en_n_i
     && modem_rst_n_i) |=> detach_req_o ##0 power_state_monitor_o)
    else $error("software off not taken");
  a_reg_delay: assert property ( // see RULE_03
    $rose(supply_en_n_i) ##1 (supply_en_n_i && !regulator_ok_o)
    |-> !regulator_ok_o [*2])
    else $error("regulator ready too early");
  a_enable_kills: assert property ( // see RULE_03
    !supply_en_n_i |=> !regulator_ok_o && !power_state_monitor_o)
    else $error("supply disable not honoured");
  a_reg_wait_len: assert property ( // see RULE_03
    $rose(regulator_ok_o) |-> en_up_q >= `MPCS_CNT_W'(REG_START_CYC))
    else $error("regulator ready before start-up time");
  a_on_after_hold: assert property ( // see RULE_07
    $rose(power_state_monitor_o)
    |-> $past(toggle_n_i) && $past(tlow_q) >= `MPCS_CNT_W'(ON_HOLD_CYC))
    else $error("modem switched on without a full released hold");
  a_off_after_req: assert property ( // see RULE_13
    $rose(detach_req_o) |-> $past(sw_off_req_i)
    || ($past(toggle_n_i) && $past(tlow_q) >= `MPCS_CNT_W'(OFF_HOLD_CYC)))
    else $error("power-down started without a request");
  a_detach_waits: assert property ( // see RULE_15
    detach_req_o && host_inputs_high_i && supply_en_n_i && modem_rst_n_i
    |=> power_state_monitor_o)
    else $error("monitor fell while host inputs were high");
  c_power_on: cover property ($rose(power_state_monitor_o));
  c_power_off: cover property ($fell(power_state_monitor_o));
  c_sw_off: cover property (sw_off_req_i && state_q == mpcs_pkg::MPCS_ON);
  c_reg_ready: cover property ($rose(regulator_ok_o));
  c_detach_wait: cover property (detach_req_o && host_inputs_high_i);
endmodule : mpcs_power_sequencer

/* verilog/mpcs_regs.svh */
`ifndef MPCS_REGS_SVH
`define MPCS_REGS_SVH
// ----------------------------------------------------------------------
// timing, 10 MHz core clock
// ----------------------------------------------------------------------
`define MPCS_CLK_HZ 10000000
`define MPCS_REG_START_MS 2
`define MPCS_REG_START_CYC ((`MPCS_REG_START_MS * `MPCS_CLK_HZ) / 1000)
`define MPCS_ON_HOLD_S 5
`define MPCS_ON_HOLD_CYC (`MPCS_ON_HOLD_S * `MPCS_CLK_HZ)
`define MPCS_OFF_HOLD_S 3
`define MPCS_OFF_HOLD_CYC (`MPCS_OFF_HOLD_S * `MPCS_CLK_HZ)
`define MPCS_DETACH_CYC 100
`define MPCS_CNT_W 32
`endif

/* verilog/mpcs_pkg.sv */
package mpcs_pkg;
  typedef enum logic [2:0] {
    MPCS_OFF = 3'b000,
    MPCS_REG_START = 3'b001,
    MPCS_ON = 3'b010,
    MPCS_DETACH = 3'b011,
    MPCS_DISABLED = 3'b100
  } mpcs_state_t;
endpackage : mpcs_pkg

/* tb/mpcs_host_model.sv */
`timescale 1ns/100ps
module mpcs_host_model (
  // clock
  input wire logic core_clk_i,
  // commands from the bench
  input wire logic sup_off_i,
  input wire logic rst_i,
  input wire logic press_i,
  // open-drain enables, low pulls the wire down
  output logic sup_oe_n_o = 1'h1,
  output logic rst_oe_n_o = 1'h1,
  output logic tog_oe_n_o = 1'h1
);
  // never drives high: the modem pull-ups make the high level
  always @(posedge core_clk_i) begin
    sup_oe_n_o <= !sup_off_i;
    rst_oe_n_o <= !rst_i;
    tog_oe_n_o <= !press_i;
  end
endmodule : mpcs_host_model

/* tb/modem_power_control_sequencer_tb.sv */
`timescale 1ns/100ps
module modem_power_control_sequencer_tb;
  // ----------------------------------------------------------------------
  // set-up
  // ----------------------------------------------------------------------
  // supply and reset holds scale with the regulator start-up count
  localparam int REG_CYC = 20;
  localparam int SUP_HOLD = 5 * REG_CYC + 2;
  localparam int RST_HOLD = 100 * REG_CYC + 2;
  // all scenarios together take about 2400 cycles
  localparam int WDOG_CYC = 5000;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic sup_off = 1'h0, rst_req = 1'h0, press = 1'h0;
  logic hi_in = 1'h0, sw_off = 1'h0, det_done = 1'h0;
  logic sup_oe_n, rst_oe_n, tog_oe_n, det_req, mon, aux, reg_ok;
  int err_total = 0;
  int num_checks = 0;
  // released wires read high through the pull-ups
  wire logic sup_w = sup_oe_n ? 1'h1 : 1'h0;
  wire logic rst_w = rst_oe_n ? 1'h1 : 1'h0;
  wire logic tog_w = tog_oe_n ? 1'h1 : 1'h0;
  initial begin
    forever #50 clk = ~clk;
  end
  mpcs_host_model host (.core_clk_i(clk), .sup_off_i(sup_off),
    .rst_i(rst_req), .press_i(press), .sup_oe_n_o(sup_oe_n),
    .rst_oe_n_o(rst_oe_n), .tog_oe_n_o(tog_oe_n));
  mpcs_power_sequencer #(.ON_HOLD_CYC(50), .OFF_HOLD_CYC(30),
    .REG_START_CYC(REG_CYC)) uut (.core_clk_i(clk), .resetn_i(rstn),
    .supply_en_n_i(sup_w), .modem_rst_n_i(rst_w), .toggle_n_i(tog_w),
    .host_inputs_high_i(hi_in), .sw_off_req_i(sw_off),
    .detach_req_o(det_req), .detach_done_i(det_done),
    .power_state_monitor_o(mon), .auxiliary_supply_out_o(aux),
    .regulator_ok_o(reg_ok));
  task automatic test_done;
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // two cycles beyond the minimum give the hold its margin
  task automatic hold(input int n);
    press <= 1'h1;
    cyc(n);
    press <= 1'h0;
    cyc(3);
  endtask : hold
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_on;
    hi_in <= 1'h0;
    hold(10);
    chk("mon", 1'h0, mon);
    hold(52);
    chk("mon", 1'h1, mon);
    chk("aux", 1'h1, aux);
  endtask : t_on
  task automatic t_off;
    hold(32);
    chk("det_req", 1'h1, det_req);
    chk("mon", 1'h1, mon);
    hi_in <= 1'h1;
    det_done <= 1'h1;
    cyc(3);
    chk("mon", 1'h1, mon);
    hi_in <= 1'h0;
    cyc(3);
    chk("mon", 1'h0, mon);
    chk("aux", 1'h0, aux);
    chk("det_req", 1'h0, det_req);
    det_done <= 1'h0;
  endtask : t_off
  task automatic t_sw;
    hold(52);
    chk("mon", 1'h1, mon);
    sw_off <= 1'h1;
    cyc(1);
    sw_off <= 1'h0;
    cyc(2);
    chk("det_req", 1'h1, det_req);
    det_done <= 1'h1;
    cyc(3);
    chk("mon", 1'h0, mon);
    det_done <= 1'h0;
    // a command while off is ignored
    sw_off <= 1'h1;
    cyc(1);
    sw_off <= 1'h0;
    cyc(2);
    chk("det_req", 1'h0, det_req);
  endtask : t_sw
  task automatic t_cut;
    hold(52);
    chk("mon", 1'h1, mon);
    rst_req <= 1'h1;
    cyc(RST_HOLD);
    chk("mon", 1'h0, mon);
    rst_req <= 1'h0;
    sup_off <= 1'h1;
    cyc(SUP_HOLD);
    chk("reg_ok", 1'h0, reg_ok);
    sup_off <= 1'h0;
    // wire high one edge later, seen the next, then the start-up count
    cyc(REG_CYC + 3);
    chk("reg_ok", 1'h1, reg_ok);
  endtask : t_cut
  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    cyc(8);
    rstn <= 1'h1;
    cyc(24);
    chk("reg_ok", 1'h1, reg_ok);
    chk("mon", 1'h0, mon);
    t_on;
    t_off;
    t_sw;
    t_cut;
    test_done;
  end
  initial begin
    repeat (WDOG_CYC) @(posedge clk);
    err_total++;
    test_done;
  end
endmodule : modem_power_control_sequencer_tb
